// File: rtl/vcp_pkg.sv
package vcp_pkg;

    // ----------------------------------------
    // Version packet layout
    // ----------------------------------------
    localparam logic [3:0] IDX_HDR = 4'h0;
    localparam logic [3:0] IDX_STREAM = 4'h1;
    localparam logic [3:0] IDX_OUI = 4'h2;
    localparam logic [3:0] IDX_CLASS = 4'h3;
    localparam logic [3:0] IDX_TS_INT = 4'h4;
    localparam logic [3:0] IDX_TS_FRAC_HI = 4'h5;
    localparam logic [3:0] IDX_TS_FRAC_LO = 4'h6;
    localparam logic [3:0] IDX_CIF0 = 4'h7;
    localparam logic [3:0] IDX_CIF1 = 4'h8;
    localparam logic [3:0] IDX_SPEC = 4'h9;
    localparam logic [3:0] IDX_VERSION = 4'hA;
    localparam logic [3:0] IDX_LAST = 4'hA;

    localparam logic [3:0] HDR_TYPE = 4'h5;
    localparam logic HDR_CLASS_ID = 1'h1;
    localparam logic [1:0] HDR_RSVD = 2'h0;
    localparam logic HDR_TSM = 1'h1;
    localparam logic [1:0] HDR_TSF = 2'h2;
    localparam logic [15:0] PKT_SIZE = 16'h000B;
    localparam logic [15:0] INFO_CLASS = 16'h0001;
    localparam logic [15:0] PKT_CLASS = 16'h0004;
    localparam logic [31:0] CIF0_CHANGED = 32'h8000_0002;
    localparam logic [31:0] CIF0_SAME = 32'h0000_0002;
    localparam logic [30:0] CIF0_FLAGS = 31'h0000_0002;
    localparam logic [31:0] CIF1_WORD = 32'h0000_000C;
    localparam logic [31:0] SPEC_VERSION = 32'h0000_0004;
    localparam logic [3:0] SEQ_RESET = 4'h0;

    // ----------------------------------------
    // Version word codes
    // ----------------------------------------
    localparam logic [3:0] TYPE_NARROW = 4'h0;
    localparam logic [3:0] TYPE_WIDE = 4'h1;
    localparam logic [5:0] IFREV_V1 = 6'h00;

    // ----------------------------------------
    // State and event indicator word
    // ----------------------------------------
    localparam int SEI_TIME_BIT = 19;
    localparam int SEI_FREQ_BIT = 17;

    // ----------------------------------------
    // Payload format limits
    // ----------------------------------------
    localparam logic [1:0] CPLX_CARTESIAN = 2'h1;
    localparam logic [4:0] ITEM_SIGNED_FIXED = 5'h00;
    localparam logic [6:0] MIN_SAMPLE_W = 7'h04;
    localparam logic [6:0] MAX_SAMPLE_W = 7'h10;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam longint REFRESH_PERIOD_MS = 1000;
    localparam longint CLK_KHZ = 250000;
    localparam longint REFRESH_CYCLES = REFRESH_PERIOD_MS * CLK_KHZ;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [2:0] {SRC_NONE, SRC_IRIG_B, SRC_IRIG_DC, SRC_PPS, SRC_NTP, SRC_GPS}
        time_src_t;
    typedef enum logic {TX_IDLE, TX_SEND} tx_state_t;

    typedef struct packed {
        logic [6:0] year;
        logic [8:0] day;
        logic [5:0] revision;
        logic [3:0] dev_type;
        logic [5:0] interface_revision_field;
    } version_cfg_t;

    typedef struct packed {
        logic link_efficient;
        logic [1:0] complex_type;
        logic [4:0] item_format;
        logic comp_repeat;
        logic [2:0] event_tag_size;
        logic [3:0] channel_tag_size;
        logic [5:0] pack_size_m1;
        logic [5:0] item_size_m1;
    } payload_fmt_t;

    typedef struct packed {
        tx_state_t tx_state;
        logic [3:0] tx_idx;
        logic [3:0] seq;
        logic send_pending;
        logic ctx_changed;
        logic [31:0] ts_int;
        logic [63:0] ts_frac;
        logic [31:0] tx_data;
        logic tx_valid;
        logic tx_last;
        logic [31:0] refresh_cnt;
        logic [31:0] sei_word;
        logic sei_valid;
        logic [3:0] rx_idx;
        logic rx_good;
        logic mode_valid;
        logic mode_wideband;
        logic mode_update;
        logic peer_time_lock;
        logic peer_freq_lock;
        logic prog_delay_ok;
        logic measure_ok;
        logic [31:0] meas_delay;
        logic [31:0] net_delay;
        logic fmt_ok;
    } state_t;

endpackage : vcp_pkg

// File: rtl/version_context_packet_framer.sv
// What this block does
// - indicator word: time lock bit 19, freq bit 17
// - time lock only from listed time sources
// - lock indicators refreshed about once per second
// - receiver derives delay-mode and measurement permissions
// - peer time unlocked forces delays to zero
// - payload must be complex, link-efficient, signed, untagged
// - sample width 4..16, no repeats, no gaps
// - version packet carries type, version, time
// - sender builds packet, receiver picks matching format
// - version details sit under second indicator word
// - vendor identifier field defaults to fixed value
// - information class fixed at one
// - packet class is four
// - spec-version word equals four
// - receiver switches to compatible mode when possible
// - version word holds year, day, revision
// - version word holds device type, interface revision
// - indicator words flag only the listed fields
// - sequence number increments modulo sixteen per packet
`timescale 1ns/1ps
`default_nettype none

module version_context_packet_framer #(
    parameter int unsigned REFRESH_CYCLES = 32'(vcp_pkg::REFRESH_CYCLES),
    // Arbitrary neutral identifier
    parameter logic [23:0] VENDOR_OUI = 24'h5A5A5A
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Local configuration and time
    input wire logic [31:0] stream_id_i,
    input wire logic [1:0] tsi_i,
    input wire vcp_pkg::version_cfg_t version_cfg_i,
    input wire logic [31:0] ts_int_i,
    input wire logic [63:0] ts_frac_i,
    input wire logic send_req_i,
    input wire logic ctx_change_i,
    // Local reference status
    input wire vcp_pkg::time_src_t time_src_i,
    input wire logic time_ref_locked_i,
    input wire logic freq_ref_locked_i,
    // Outgoing packet stream
    output logic [31:0] tx_data_o,
    output logic tx_valid_o,
    output logic tx_last_o,
    input wire logic tx_ready_i,
    // Outgoing indicator word
    output logic [31:0] sei_word_o,
    output logic sei_valid_o,
    // Incoming packet stream
    input wire logic [31:0] rx_data_i,
    input wire logic rx_valid_i,
    input wire logic rx_last_i,
    // Incoming indicator word
    input wire logic [31:0] rx_sei_word_i,
    input wire logic rx_sei_valid_i,
    // Delay measurements
    input wire logic [31:0] meas_delay_i,
    input wire logic [31:0] net_delay_i,
    output logic [31:0] meas_delay_o,
    output logic [31:0] net_delay_o,
    // Receiver decisions
    output logic mode_valid_o,
    output logic mode_wideband_o,
    output logic mode_update_o,
    output logic prog_delay_ok_o,
    output logic measure_ok_o,
    // Payload format check
    input wire vcp_pkg::payload_fmt_t payload_fmt_i,
    output logic fmt_ok_o
);

    // ----------------------------------------
    // Parameter check
    // ----------------------------------------
    if (REFRESH_CYCLES < 2)
    begin : g_bad_refresh
        $error("REFRESH_CYCLES must be at least 2");
    end

    vcp_pkg::state_t s;
    vcp_pkg::state_t next_s;

    // ----------------------------------------
    // Outgoing word builder
    // ----------------------------------------
    function automatic logic [31:0] tx_word(
        input logic [3:0] idx,
        input vcp_pkg::state_t st,
        input logic [31:0] sid,
        input logic [1:0] tsi,
        input vcp_pkg::version_cfg_t vc
    );
        logic [31:0] w;
        w = 32'h0000_0000;
        unique case (idx)
            vcp_pkg::IDX_HDR: w = {vcp_pkg::HDR_TYPE, vcp_pkg::HDR_CLASS_ID, vcp_pkg::HDR_RSVD,
                vcp_pkg::HDR_TSM, tsi, vcp_pkg::HDR_TSF, st.seq, vcp_pkg::PKT_SIZE};
            vcp_pkg::IDX_STREAM: w = sid;
            vcp_pkg::IDX_OUI: w = {8'h00, VENDOR_OUI};
            vcp_pkg::IDX_CLASS: w = {vcp_pkg::INFO_CLASS, vcp_pkg::PKT_CLASS};
            vcp_pkg::IDX_TS_INT: w = st.ts_int;
            vcp_pkg::IDX_TS_FRAC_HI: w = st.ts_frac[63:32];
            vcp_pkg::IDX_TS_FRAC_LO: w = st.ts_frac[31:0];
            vcp_pkg::IDX_CIF0: w = st.ctx_changed ? vcp_pkg::CIF0_CHANGED : vcp_pkg::CIF0_SAME;
            vcp_pkg::IDX_CIF1: w = vcp_pkg::CIF1_WORD;
            vcp_pkg::IDX_SPEC: w = vcp_pkg::SPEC_VERSION;
            vcp_pkg::IDX_VERSION: w = {vc.year, vc.day, vc.revision, vc.dev_type,
                vc.interface_revision_field};
            default: w = 32'h0000_0000;
        endcase
        return w;
    endfunction : tx_word

    // ----------------------------------------
    // Incoming word check
    // ----------------------------------------
    function automatic logic rx_word_ok(input logic [3:0] idx, input logic [31:0] d);
        logic ok;
        ok = 1'b1;
        unique case (idx)
            vcp_pkg::IDX_HDR: ok = d[31:28] == vcp_pkg::HDR_TYPE && d[27] == vcp_pkg::HDR_CLASS_ID
                && d[15:0] == vcp_pkg::PKT_SIZE;
            vcp_pkg::IDX_CLASS: ok = d == {vcp_pkg::INFO_CLASS, vcp_pkg::PKT_CLASS};
            vcp_pkg::IDX_CIF0: ok = d[30:0] == vcp_pkg::CIF0_FLAGS;
            vcp_pkg::IDX_CIF1: ok = d == vcp_pkg::CIF1_WORD;
            vcp_pkg::IDX_SPEC: ok = d == vcp_pkg::SPEC_VERSION;
            default: ok = 1'b1;
        endcase
        return ok;
    endfunction : rx_word_ok

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        logic time_ok;
        logic word_ok;
        logic [6:0] width;
        time_ok = 1'b0;
        word_ok = 1'b0;
        width = 7'h00;
        next_s = s;
        next_s.sei_valid = 1'b0;
        next_s.mode_update = 1'b0;

        if (send_req_i)
        begin
            next_s.send_pending = 1'b1;
        end

        // Transmit sequencing
        unique case (s.tx_state)
            vcp_pkg::TX_IDLE:
            begin
                if (s.send_pending)
                begin
                    next_s.send_pending = send_req_i;
                    next_s.ts_int = ts_int_i;
                    next_s.ts_frac = ts_frac_i;
                    next_s.tx_idx = vcp_pkg::IDX_HDR;
                    next_s.tx_data = tx_word(vcp_pkg::IDX_HDR, s, stream_id_i, tsi_i,
                        version_cfg_i);
                    next_s.tx_valid = 1'b1;
                    next_s.tx_last = 1'b0;
                    next_s.tx_state = vcp_pkg::TX_SEND;
                end
            end
            vcp_pkg::TX_SEND:
            begin
                if (tx_ready_i)
                begin
                    if (s.tx_idx == vcp_pkg::IDX_LAST)
                    begin
                        next_s.tx_valid = 1'b0;
                        next_s.tx_last = 1'b0;
                        next_s.seq = s.seq + 4'h1;
                        next_s.tx_state = vcp_pkg::TX_IDLE;
                    end
                    else
                    begin
                        next_s.tx_idx = s.tx_idx + 4'h1;
                        next_s.tx_data = tx_word(s.tx_idx + 4'h1, s, stream_id_i, tsi_i,
                            version_cfg_i);
                        next_s.tx_last = (s.tx_idx + 4'h1) == vcp_pkg::IDX_LAST;
                        if (s.tx_idx + 4'h1 == vcp_pkg::IDX_CIF0)
                        begin
                            next_s.ctx_changed = 1'b0;
                        end
                    end
                end
            end
        endcase

        if (ctx_change_i)
        begin
            next_s.ctx_changed = 1'b1;
        end

        time_ok = time_ref_locked_i && time_src_i != vcp_pkg::SRC_NONE;

        if (s.refresh_cnt == REFRESH_CYCLES - 1)
        begin
            next_s.refresh_cnt = 32'h0000_0000;
            next_s.sei_word = 32'h0000_0000;
            next_s.sei_word[vcp_pkg::SEI_TIME_BIT] = time_ok;
            next_s.sei_word[vcp_pkg::SEI_FREQ_BIT] = freq_ref_locked_i;
            next_s.sei_valid = 1'b1;
        end
        else
        begin
            next_s.refresh_cnt = s.refresh_cnt + 32'h0000_0001;
        end

        if (rx_sei_valid_i)
        begin
            next_s.peer_time_lock = rx_sei_word_i[vcp_pkg::SEI_TIME_BIT];
            next_s.peer_freq_lock = rx_sei_word_i[vcp_pkg::SEI_FREQ_BIT];
        end
        next_s.prog_delay_ok = s.peer_time_lock && s.peer_freq_lock;
        next_s.measure_ok = s.peer_time_lock;

        next_s.meas_delay = s.peer_time_lock ? meas_delay_i : 32'h0000_0000;
        next_s.net_delay = s.peer_time_lock ? net_delay_i : 32'h0000_0000;

        if (rx_valid_i)
        begin
            word_ok = rx_word_ok(s.rx_idx, rx_data_i);
            next_s.rx_good = (s.rx_idx == vcp_pkg::IDX_HDR) ? word_ok : (s.rx_good && word_ok);
            if (s.rx_idx != 4'hF)
            begin
                next_s.rx_idx = s.rx_idx + 4'h1;
            end
            if (rx_last_i)
            begin
                next_s.rx_idx = vcp_pkg::IDX_HDR;
                if (s.rx_good && word_ok && s.rx_idx == vcp_pkg::IDX_VERSION
                    && rx_data_i[5:0] == vcp_pkg::IFREV_V1
                    && (rx_data_i[9:6] == vcp_pkg::TYPE_NARROW
                    || rx_data_i[9:6] == vcp_pkg::TYPE_WIDE))
                begin
                    next_s.mode_valid = 1'b1;
                    next_s.mode_wideband = rx_data_i[9:6] == vcp_pkg::TYPE_WIDE;
                    next_s.mode_update = 1'b1;
                end
            end
        end

        width = {1'b0, payload_fmt_i.item_size_m1} + 7'h01;
        next_s.fmt_ok = payload_fmt_i.link_efficient
            && payload_fmt_i.complex_type == vcp_pkg::CPLX_CARTESIAN
            && payload_fmt_i.item_format == vcp_pkg::ITEM_SIGNED_FIXED
            && !payload_fmt_i.comp_repeat
            && payload_fmt_i.event_tag_size == 3'h0
            && payload_fmt_i.channel_tag_size == 4'h0
            && payload_fmt_i.pack_size_m1 == payload_fmt_i.item_size_m1
            && width >= vcp_pkg::MIN_SAMPLE_W && width <= vcp_pkg::MAX_SAMPLE_W;
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            s <= '0;
            s.tx_state <= vcp_pkg::TX_IDLE;
            s.seq <= vcp_pkg::SEQ_RESET;
        end
        else
        begin
            s <= next_s;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign tx_data_o = s.tx_data;
    assign tx_valid_o = s.tx_valid;
    assign tx_last_o = s.tx_last;
    assign sei_word_o = s.sei_word;
    assign sei_valid_o = s.sei_valid;
    assign meas_delay_o = s.meas_delay;
    assign net_delay_o = s.net_delay;
    assign mode_valid_o = s.mode_valid;
    assign mode_wideband_o = s.mode_wideband;
    assign mode_update_o = s.mode_update;
    assign prog_delay_ok_o = s.prog_delay_ok;
    assign measure_ok_o = s.measure_ok;
    assign fmt_ok_o = s.fmt_ok;

endmodule : version_context_packet_framer

`default_nettype wire

// File: testbench/vcp_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module vcp_assertions #(
    parameter int unsigned REFRESH_CYCLES = 16
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Transmit stream
    input wire logic [31:0] tx_data_o,
    input wire logic tx_valid_o,
    input wire logic tx_last_o,
    input wire logic tx_ready_i,
    // Indicator and decisions
    input wire logic [31:0] sei_word_o,
    input wire logic sei_valid_o,
    input wire logic [31:0] meas_delay_o,
    input wire logic [31:0] net_delay_o,
    input wire logic prog_delay_ok_o,
    input wire logic measure_ok_o
);
    // ----
    // Word index and refresh spacing
    // ----
    logic [3:0] widx;
    logic [31:0] gap;
    logic seen;
    logic [3:0] last_seq;
    logic hdr_seen;
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            widx <= 4'h0;
            gap <= 32'h0;
            seen <= 1'h0;
            last_seq <= 4'h0;
            hdr_seen <= 1'h0;
        end
        else
        begin
            if (tx_valid_o && tx_ready_i)
                widx <= tx_last_o ? 4'h0 : widx + 4'h1;
            if (tx_valid_o && tx_ready_i && widx == 4'h0)
            begin
                last_seq <= tx_data_o[19:16];
                hdr_seen <= 1'h1;
            end
            gap <= sei_valid_o ? 32'h0 : gap + 32'h1;
            seen <= seen | sei_valid_o;
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    // ----
    // Properties
    // ----
    sequence s_wait;
        tx_valid_o && !tx_ready_i;
    endsequence
    sequence s_end;
        tx_valid_o && tx_ready_i && tx_last_o;
    endsequence
    property p_hdr;
        tx_valid_o && widx == 4'h0 |-> tx_data_o[31:24] == 8'h59 && tx_data_o[21:20] == 2'h2
            && tx_data_o[15:0] == 16'h000B;
    endproperty
    property p_class;
        tx_valid_o && widx == 4'h3 |-> tx_data_o == 32'h0001_0004;
    endproperty
    property p_cif;
        tx_valid_o && widx == 4'h8 |-> tx_data_o == 32'h0000_000C;
    endproperty
    property p_spec;
        tx_valid_o && widx == 4'h9 |-> tx_data_o == 32'h0000_0004;
    endproperty
    property p_cif0;
        tx_valid_o && widx == 4'h7 |-> tx_data_o[30:0] == 31'h0000_0002;
    endproperty
    property p_last;
        tx_valid_o && tx_last_o |-> widx == 4'hA;
    endproperty
    property p_hold;
        s_wait |=> tx_valid_o && $stable(tx_data_o);
    endproperty
    property p_gap;
        s_end |=> !tx_valid_o;
    endproperty
    property p_sei_bits;
        sei_valid_o |-> (sei_word_o & 32'hFFF5_FFFF) == 32'h0;
    endproperty
    property p_period;
        seen && sei_valid_o |-> gap == REFRESH_CYCLES - 1;
    endproperty
    property p_zero;
        !measure_ok_o |-> meas_delay_o == 32'h0 && net_delay_o == 32'h0;
    endproperty
    property p_prog;
        prog_delay_ok_o |-> measure_ok_o;
    endproperty
    property p_seq;
        tx_valid_o && widx == 4'h0 && hdr_seen |-> tx_data_o[19:16] == last_seq + 4'h1;
    endproperty

    a_hdr: assert property (p_hdr) else $error("header word wrong");
    a_class: assert property (p_class) else $error("class word wrong");
    a_cif: assert property (p_cif) else $error("second indicator wrong");
    a_spec: assert property (p_spec) else $error("spec word wrong");
    a_cif0: assert property (p_cif0) else $error("first indicator wrong");
    a_last: assert property (p_last) else $error("packet length wrong");
    a_hold: assert property (p_hold) else $error("word not held");
    a_gap: assert property (p_gap) else $error("no idle after packet");
    a_sei_bits: assert property (p_sei_bits) else $error("stray indicator bit");
    a_period: assert property (p_period) else $error("refresh spacing wrong");
    a_zero: assert property (p_zero) else $error("delay not zeroed");
    a_prog: assert property (p_prog) else $error("delay mode without time");
    a_seq: assert property (p_seq) else $error("sequence number not incremented");
endmodule : vcp_assertions

bind version_context_packet_framer vcp_assertions #(.REFRESH_CYCLES(REFRESH_CYCLES)) u_chk (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o),
    .tx_last_o(tx_last_o), .tx_ready_i(tx_ready_i), .sei_word_o(sei_word_o),
    .sei_valid_o(sei_valid_o), .meas_delay_o(meas_delay_o), .net_delay_o(net_delay_o),
    .prog_delay_ok_o(prog_delay_ok_o), .measure_ok_o(measure_ok_o));
`default_nettype wire

// File: testbench/vcp_sink_model.sv
`timescale 1ns/1ps
`default_nettype none

module vcp_sink_model (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Stream from the framer
    input wire logic [31:0] tx_data_i,
    input wire logic tx_valid_i,
    input wire logic tx_last_i,
    input wire logic slow_i,
    output logic tx_ready_o
);
    logic [31:0] words [0:10];
    logic [3:0] idx;
    logic [7:0] lfsr;
    int npkt;
    // ----
    // Receiving endpoint
    // ----
    // consume whole packet
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            idx <= 4'h0;
            npkt <= 0;
            lfsr <= 8'hA5;
            tx_ready_o <= 1'h0;
        end
        else
        begin
            lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
            tx_ready_o <= !slow_i || lfsr[0];
            if (tx_valid_i && tx_ready_o)
            begin
                words[idx] <= tx_data_i;
                idx <= tx_last_i ? 4'h0 : idx + 4'h1;
                if (tx_last_i)
                    npkt <= npkt + 1;
            end
        end
    end
endmodule : vcp_sink_model
`default_nettype wire

// File: testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    localparam int unsigned REFRESH = 16;
    // Arbitrary identifier
    localparam logic [23:0] OUI = 24'h3C3C3C;
    logic sys_clk = 1'h0, rst = 1'h1, send_req = 1'h0, ctx_change = 1'h0, tl = 1'h0, fl = 1'h0;
    logic rx_valid = 1'h0, rx_last = 1'h0, rx_sei_valid = 1'h0, slow = 1'h0, tx_ready;
    logic [1:0] tsi = 2'h1;
    logic [31:0] stream_id = 32'h0, ts_int = 32'h0, rx_data = 32'h0, rx_sei = 32'h0;
    logic [31:0] meas = 32'h0, net = 32'h0, rs = 32'hC4B5, tx_data, sei_word, meas_o, net_o;
    logic [63:0] ts_frac = 64'h0;
    logic [3:0] seq = 4'h0;
    logic tx_valid, tx_last, sei_valid, mode_valid, mode_wide, mode_upd, prog_ok, meas_ok, fmt_ok;
    vcp_pkg::version_cfg_t ver = '0;
    vcp_pkg::time_src_t src = vcp_pkg::SRC_NONE;
    vcp_pkg::payload_fmt_t fmt = '0;
    int failures = 0, num_checks = 0, cycles = 0, i, k, w;

`define CHECK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
    $display("mismatch at %0t: value differs", $time); end end

    always #2 sys_clk = ~sys_clk;

    version_context_packet_framer #(.REFRESH_CYCLES(REFRESH), .VENDOR_OUI(OUI)) dut (
        .sys_clk_i(sys_clk), .rst_i(rst), .stream_id_i(stream_id), .tsi_i(tsi),
        .version_cfg_i(ver), .ts_int_i(ts_int), .ts_frac_i(ts_frac), .send_req_i(send_req),
        .ctx_change_i(ctx_change), .time_src_i(src), .time_ref_locked_i(tl),
        .freq_ref_locked_i(fl), .tx_data_o(tx_data), .tx_valid_o(tx_valid), .tx_last_o(tx_last),
        .tx_ready_i(tx_ready), .sei_word_o(sei_word), .sei_valid_o(sei_valid),
        .rx_data_i(rx_data), .rx_valid_i(rx_valid), .rx_last_i(rx_last),
        .rx_sei_word_i(rx_sei), .rx_sei_valid_i(rx_sei_valid), .meas_delay_i(meas),
        .net_delay_i(net), .meas_delay_o(meas_o), .net_delay_o(net_o),
        .mode_valid_o(mode_valid), .mode_wideband_o(mode_wide), .mode_update_o(mode_upd),
        .prog_delay_ok_o(prog_ok), .measure_ok_o(meas_ok), .payload_fmt_i(fmt),
        .fmt_ok_o(fmt_ok));

    vcp_sink_model sink (.sys_clk_i(sys_clk), .rst_i(rst), .tx_data_i(tx_data),
        .tx_valid_i(tx_valid), .tx_last_i(tx_last), .slow_i(slow), .tx_ready_o(tx_ready));

    // ----
    // Helpers
    // ----
    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction : rnd

    function automatic logic [31:0] exp_word(int n, logic [3:0] sq, logic chg, logic [31:0] v,
        logic [31:0] spec);
        case (n)
            0: return {4'h5, 1'h1, 2'h0, 1'h1, tsi, 2'h2, sq, 16'h000B};
            1: return stream_id;
            2: return {8'h00, OUI};
            3: return 32'h0001_0004;
            4: return ts_int;
            5: return ts_frac[63:32];
            6: return ts_frac[31:0];
            7: return chg ? 32'h8000_0002 : 32'h0000_0002;
            8: return 32'h0000_000C;
            9: return spec;
            default: return v;
        endcase
    endfunction : exp_word

    function automatic logic [31:0] vw(logic [3:0] t, logic [5:0] r);
        return {7'h15, 9'h064, 6'h01, t, r};
    endfunction : vw

    task automatic send_pkt(logic chg);
        int n0;
        int j;
        @(posedge sys_clk);
        stream_id <= rnd();
        ts_int <= rnd();
        ts_frac <= {rnd(), rnd()};
        ver <= rnd();
        tsi <= 2'((rnd() % 3) + 1);
        slow <= 1'(rnd());
        send_req <= 1'h1;
        ctx_change <= chg;
        n0 = sink.npkt;
        @(posedge sys_clk);
        send_req <= 1'h0;
        ctx_change <= 1'h0;
        for (j = 0; j < 300 && sink.npkt == n0; j++)
            @(posedge sys_clk);
        #1;
        for (j = 0; j < 11; j++)
            `CHECK(sink.words[j], exp_word(j, seq, chg, ver, 32'h4))
        seq = seq + 4'h1;
    endtask : send_pkt

    task automatic wait_sei();
        int j;
        @(posedge sys_clk);
        #1;
        for (j = 0; j < 100 && sei_valid !== 1'h1; j++)
        begin
            @(posedge sys_clk);
            #1;
        end
    endtask : wait_sei

    task automatic rx_pkt(logic [31:0] v, logic [31:0] spec, logic ok, logic wide);
        int j;
        for (j = 0; j < 11; j++)
        begin
            @(posedge sys_clk);
            rx_data <= exp_word(j, 4'h0, 1'h1, v, spec);
            rx_valid <= 1'h1;
            rx_last <= (j == 10);
        end
        @(posedge sys_clk);
        rx_valid <= 1'h0;
        rx_last <= 1'h0;
        #1;
        `CHECK(mode_upd, ok)
        `CHECK(mode_wide, wide)
        `CHECK(mode_valid, 1'h1)
    endtask : rx_pkt

    task automatic report_and_stop();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            report_and_stop();
        end
    end

    // ----
    // Main sequence
    // ----
    initial
    begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'h0;
        for (i = 0; i < 18; i++)
            send_pkt(i % 3 == 0);
        for (k = 0; k < 6; k++)
        begin
            @(posedge sys_clk);
            src <= vcp_pkg::time_src_t'(k);
            tl <= 1'(rnd()) | (k == 0) | (k == 5);
            fl <= 1'(rnd());
            wait_sei();
            wait_sei();
            `CHECK(sei_word, {12'h000, tl && src != vcp_pkg::SRC_NONE, 1'h0, fl, 17'h0})
        end
        for (k = 0; k < 4; k++)
        begin
            @(posedge sys_clk);
            rx_sei <= {12'h000, k[1], 1'h0, k[0], 17'h00000};
            rx_sei_valid <= 1'h1;
            meas <= rnd() | 32'h1;
            net <= rnd() | 32'h1;
            @(posedge sys_clk);
            rx_sei_valid <= 1'h0;
            repeat (3) @(posedge sys_clk);
            #1;
            `CHECK(prog_ok, k[1] & k[0])
            `CHECK(meas_ok, k[1])
            `CHECK(meas_o, k[1] ? meas : 32'h0)
            `CHECK(net_o, k[1] ? net : 32'h0)
        end
        for (k = 0; k < 11; k++)
        begin
            @(posedge sys_clk);
            w = k == 0 ? 4 : k == 1 ? 16 : k == 8 ? 3 : k == 9 ? 17 : 4 + int'(rnd() % 13);
            fmt <= '{link_efficient: k != 2, complex_type: k == 3 ? 2'h2 : vcp_pkg::CPLX_CARTESIAN,
                item_format: k == 4 ? 5'h01 : vcp_pkg::ITEM_SIGNED_FIXED, comp_repeat: k == 5,
                event_tag_size: {2'h0, k == 6}, channel_tag_size: {3'h0, k == 7},
                pack_size_m1: 6'(k == 10 ? w : w - 1), item_size_m1: 6'(w - 1)};
            repeat (2) @(posedge sys_clk);
            #1;
            if (k >= 2 && k <= 7)
                `CHECK(fmt_ok, 1'h0)
            else
                `CHECK(fmt_ok, k < 2)
        end
        rx_pkt(vw(vcp_pkg::TYPE_WIDE, vcp_pkg::IFREV_V1), 32'h4, 1'h1, 1'h1);
        rx_pkt(vw(vcp_pkg::TYPE_NARROW, vcp_pkg::IFREV_V1), 32'h4, 1'h1, 1'h0);
        rx_pkt(vw(4'h2, vcp_pkg::IFREV_V1), 32'h4, 1'h0, 1'h0);
        rx_pkt(vw(vcp_pkg::TYPE_WIDE, vcp_pkg::IFREV_V1), 32'h5, 1'h0, 1'h0);
        rx_pkt(vw(vcp_pkg::TYPE_WIDE, 6'h01), 32'h4, 1'h0, 1'h0);
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
